//--- logic/ccm_mode_ctrl.sv
// mode select and high control logic of a capture/compare/timer unit
`timescale 1ns/10ps

module ccm_mode_ctrl import ccm_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic cap_in_i,
  input wire logic match_i,
  input wire logic period_evt_i,
  input wire logic trig_evt_i,
  input wire logic trigger_i,
  output logic cmp_out_o,
  output logic capture_o,
  output logic irq_o,
  output logic timebase_restart_o,
  output logic pulse_gen_en_o,
  output logic buffered_o,
  output logic time32_o,
  output logic period_rollover_o,
  output logic one_shot_o,
  output logic alt_sync_o,
  output logic [4:0] sync_select_o,
  output ccm_func_t func_o
);

  ccm_state_t st;
  ccm_state_t next_st;
  ccm_func_t func;
  logic is_cap;
  logic [3:0] mode_field;
  logic [3:0] postscale;
  logic req;
  logic wr;
  logic rise;
  logic fall;
  logic cap_evt;
  logic cnt_evt;
  logic [15:0] wmask;
  logic [15:0] wdat;

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  assign is_cap = st.low[CCM_SEL_BIT];
  assign mode_field = st.low[3:0];
  assign postscale = st.high[11:8];

  always_comb begin
    func = CCM_F_NONE;
    if (is_cap) begin
      unique case (mode_field)
        CCM_CAP_BOTH0, CCM_CAP_RISE, CCM_CAP_FALL, CCM_CAP_BOTH,
        CCM_CAP_RISE4, CCM_CAP_RISE16: func = CCM_F_CAPTURE;
        default: func = CCM_F_NONE;
      endcase
    end else begin
      unique case (mode_field)
        CCM_CMP_TIMER: func = CCM_F_TIMER;
        CCM_CMP_HIGH: func = CCM_F_SET_HIGH;
        CCM_CMP_LOW: func = CCM_F_SET_LOW;
        CCM_CMP_TOGGLE: func = CCM_F_TOGGLE;
        CCM_CMP_DUAL: func = CCM_F_DUAL;
        CCM_CMP_DUALB: func = CCM_F_DUAL_BUF;
        CCM_CMP_CENTER: func = CCM_F_CENTER;
        CCM_CMP_VFREQ: func = CCM_F_VFREQ;
        CCM_CMP_EXT: func = CCM_F_EXTERNAL;
        default: func = CCM_F_NONE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // capture edge qualification
  // ---------------------------------------------------------------
  assign rise = cap_in_i & ~st.cap_prev;
  assign fall = ~cap_in_i & st.cap_prev;

  always_comb begin
    cap_evt = 1'b0;
    if (func == CCM_F_CAPTURE) begin
      unique case (mode_field)
        CCM_CAP_BOTH0, CCM_CAP_BOTH: cap_evt = rise | fall;
        CCM_CAP_RISE: cap_evt = rise;
        CCM_CAP_FALL: cap_evt = fall;
        CCM_CAP_RISE4:
          cap_evt = rise && st.edge_cnt[1:0] == CCM_DIV4[1:0];
        CCM_CAP_RISE16: cap_evt = rise && st.edge_cnt == CCM_DIV16;
        default: cap_evt = 1'b0;
      endcase
    end
  end

  // postscaler counts captures in capture operation; in compare
  // operation the source bit selects trigger or period events
  always_comb begin
    if (func == CCM_F_NONE) begin
      cnt_evt = 1'b0;
    end else if (is_cap) begin
      cnt_evt = cap_evt;
    end else if (st.high[CCM_SRC_BIT]) begin
      cnt_evt = trig_evt_i;
    end else begin
      cnt_evt = period_evt_i;
    end
  end

  // ---------------------------------------------------------------
  // wishbone slave: one wait state, ack one cycle after strobe
  // ---------------------------------------------------------------
  assign req = cyc_i & stb_i & ~st.ack;
  assign wr = req & we_i;
  assign wmask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wdat = dat_i[15:0];

  always_comb begin
    next_st = st;
    next_st.ack = req;
    next_st.cap_prev = cap_in_i;
    next_st.capture = cap_evt;
    next_st.irq = 1'b0;
    if (wr && adr_i == CCM_ADDR_LOW) begin
      next_st.low = (st.low & ~(wmask & CCM_LOW_WMASK))
        | (wdat & wmask & CCM_LOW_WMASK);
    end
    if (wr && adr_i == CCM_ADDR_HIGH) begin
      next_st.high = (st.high & ~(wmask & CCM_HIGH_WMASK))
        | (wdat & wmask & CCM_HIGH_WMASK);
    end
    if (req) begin
      unique case (adr_i)
        CCM_ADDR_LOW: next_st.rdata = st.low;
        CCM_ADDR_HIGH: next_st.rdata = st.high & CCM_HIGH_WMASK;
        CCM_ADDR_STAT: next_st.rdata = {11'h000, st.cmp_out, func};
        default: next_st.rdata = 16'h0000;
      endcase
    end
    if (func == CCM_F_CAPTURE && rise) begin
      next_st.edge_cnt = st.edge_cnt + 4'h1;
    end
    if (func != CCM_F_CAPTURE) begin
      next_st.edge_cnt = 4'h0;
    end
    if (cnt_evt) begin
      if (st.post_cnt >= postscale) begin
        next_st.post_cnt = 4'h0;
        next_st.irq = 1'b1;
      end else begin
        next_st.post_cnt = st.post_cnt + 4'h1;
      end
    end
    if (match_i && !is_cap) begin
      unique case (func)
        CCM_F_SET_HIGH: next_st.cmp_out = 1'b1;
        CCM_F_SET_LOW: next_st.cmp_out = 1'b0;
        CCM_F_TOGGLE: next_st.cmp_out = ~st.cmp_out;
        default: next_st.cmp_out = st.cmp_out;
      endcase
    end
    if (func == CCM_F_TIMER || func == CCM_F_NONE) begin
      next_st.cmp_out = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.low <= CCM_LOW_RESET;
      st.high <= CCM_HIGH_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ack_o = st.ack;
  assign dat_o = {16'h0000, st.rdata};
  assign cmp_out_o = st.cmp_out;
  assign capture_o = st.capture;
  assign irq_o = st.irq;
  // retrigger only when both enables stand
  assign timebase_restart_o = trigger_i & st.high[CCM_TRG_BIT]
    & st.high[CCM_RTRG_BIT] & (func != CCM_F_NONE);
  assign pulse_gen_en_o = !is_cap && func != CCM_F_EXTERNAL
    && func != CCM_F_NONE && func != CCM_F_TIMER;
  assign buffered_o = func == CCM_F_DUAL_BUF || func == CCM_F_CENTER;
  assign time32_o = st.low[CCM_T32_BIT];
  assign sync_select_o = st.high[4:0];
  assign period_rollover_o = st.high[4:0] == CCM_SYNC_NONE;
  assign one_shot_o = st.high[CCM_ONE_BIT];
  assign alt_sync_o = st.high[CCM_ALT_BIT];
  assign func_o = func;

  // ---------------------------------------------------------------
  // capture checks
  // ---------------------------------------------------------------
  a_rsvd_cap_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    is_cap && mode_field[3] |=> !capture_o)
    else $error("capture in reserved mode");
  a_rsvd_cap_code: assert property (
    @(posedge clk_i) disable iff (rst_i)
    is_cap && mode_field > CCM_CAP_RISE16 |-> func == CCM_F_NONE)
    else $error("reserved capture code decoded");
  a_rise16_gap: assert property (
    @(posedge clk_i) disable iff (rst_i)
    capture_o && $past(mode_field) == CCM_CAP_RISE16 && $past(is_cap)
    |-> $past(st.edge_cnt) == CCM_DIV16)
    else $error("16th edge capture misplaced");
  a_rise16_hit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    is_cap && mode_field == CCM_CAP_RISE16 && rise
    && st.edge_cnt == CCM_DIV16 |=> capture_o)
    else $error("16th rising edge not captured");
  a_rise4_gap: assert property (
    @(posedge clk_i) disable iff (rst_i)
    capture_o && $past(mode_field) == CCM_CAP_RISE4 && $past(is_cap)
    |-> $past(st.edge_cnt[1:0]) == CCM_DIV4[1:0])
    else $error("4th edge capture misplaced");
  a_rise4_hit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    is_cap && mode_field == CCM_CAP_RISE4 && rise
    && st.edge_cnt[1:0] == CCM_DIV4[1:0] |=> capture_o)
    else $error("4th rising edge not captured");
  a_both_capture: assert property (
    @(posedge clk_i) disable iff (rst_i)
    is_cap && mode_field == CCM_CAP_BOTH && (rise || fall) |=> capture_o)
    else $error("edge not captured");
  a_edge_detect: assert property (
    @(posedge clk_i) disable iff (rst_i)
    is_cap && mode_field == CCM_CAP_BOTH0 && (rise || fall) |=> capture_o)
    else $error("edge detect missed an edge");
  a_rise_capture: assert property (
    @(posedge clk_i) disable iff (rst_i)
    is_cap && mode_field == CCM_CAP_RISE && rise |=> capture_o)
    else $error("rising edge not captured");
  a_fall_capture: assert property (
    @(posedge clk_i) disable iff (rst_i)
    is_cap && mode_field == CCM_CAP_FALL && fall && $stable(st.low)
    |=> capture_o)
    else $error("falling edge not captured");
  a_cmp_no_capture: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !is_cap |=> !capture_o)
    else $error("capture taken in compare operation");

  // ---------------------------------------------------------------
  // compare checks
  // ---------------------------------------------------------------
  a_ext_no_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    func == CCM_F_EXTERNAL |-> !pulse_gen_en_o)
    else $error("pulse generator on in external mode");
  a_rsvd_cmp_code: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !is_cap && mode_field[3] && mode_field != CCM_CMP_EXT
    |-> func == CCM_F_NONE)
    else $error("reserved compare code decoded");
  a_vfreq_decode: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !is_cap && mode_field == CCM_CMP_VFREQ
    |-> func == CCM_F_VFREQ && pulse_gen_en_o)
    else $error("variable frequency mode not selected");
  a_center_decode: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !is_cap && mode_field == CCM_CMP_CENTER
    |-> func == CCM_F_CENTER && buffered_o)
    else $error("center aligned mode not selected");
  a_dual_buf: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !is_cap && mode_field == CCM_CMP_DUALB
    |-> func == CCM_F_DUAL_BUF && buffered_o)
    else $error("buffered dual edge mode not selected");
  a_dual_plain: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !is_cap && mode_field == CCM_CMP_DUAL
    |-> func == CCM_F_DUAL && !buffered_o)
    else $error("unbuffered dual edge mode not selected");
  a_toggle_match: assert property (
    @(posedge clk_i) disable iff (rst_i)
    func == CCM_F_TOGGLE && match_i ##1 func == CCM_F_TOGGLE
    |-> cmp_out_o != $past(cmp_out_o))
    else $error("output did not toggle");
  a_cmp_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !match_i && func != CCM_F_TIMER && func != CCM_F_NONE
    |=> $stable(cmp_out_o))
    else $error("output moved without a match");
  a_low_on_match: assert property (
    @(posedge clk_i) disable iff (rst_i)
    func == CCM_F_SET_LOW && match_i |=> !cmp_out_o)
    else $error("output not driven low");
  a_high_on_match: assert property (
    @(posedge clk_i) disable iff (rst_i)
    func == CCM_F_SET_HIGH && match_i |=> cmp_out_o)
    else $error("output not driven high");
  a_timer_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    func == CCM_F_TIMER |=> !cmp_out_o)
    else $error("timer mode drove output");
  a_rsvd_cmp_quiet: assert property (
    @(posedge clk_i) disable iff (rst_i)
    func == CCM_F_NONE |=> !cmp_out_o)
    else $error("output driven in reserved mode");

  // ---------------------------------------------------------------
  // control register and interrupt checks
  // ---------------------------------------------------------------
  a_trig_counts: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !is_cap && func != CCM_F_NONE && st.high[CCM_SRC_BIT]
    && postscale == '0 && trig_evt_i |=> irq_o)
    else $error("trigger event not counted");
  a_trig_only: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !is_cap && st.high[CCM_SRC_BIT] && !trig_evt_i |=> !irq_o)
    else $error("interrupt without trigger event");
  a_period_counts: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !is_cap && func != CCM_F_NONE && !st.high[CCM_SRC_BIT]
    && postscale == '0 && period_evt_i |=> irq_o)
    else $error("period event not counted");
  a_period_only: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !is_cap && !st.high[CCM_SRC_BIT] && !period_evt_i |=> !irq_o)
    else $error("interrupt without period event");
  a_retrig_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    timebase_restart_o |-> st.high[CCM_RTRG_BIT] && st.high[CCM_TRG_BIT])
    else $error("retrigger without enable");
  a_hi_unimpl: assert property (
    @(posedge clk_i) disable iff (rst_i)
    st.high[13:12] == 2'h0)
    else $error("unimplemented bits set");
  a_post_bound: assert property (
    @(posedge clk_i) disable iff (rst_i)
    irq_o |-> $past(st.post_cnt) == $past(postscale))
    else $error("interrupt count wrong");
  a_irq_spacing: assert property (
    @(posedge clk_i) disable iff (rst_i)
    irq_o && postscale != '0 |=> !irq_o)
    else $error("interrupts too close together");
  a_rsvd_no_irq: assert property (
    @(posedge clk_i) disable iff (rst_i)
    func == CCM_F_NONE && $stable(st.low) |=> !irq_o)
    else $error("interrupt in reserved mode");

  c_capture16: cover property (@(posedge clk_i)
    capture_o && mode_field == CCM_CAP_RISE16);
  c_capture4: cover property (@(posedge clk_i)
    capture_o && mode_field == CCM_CAP_RISE4);
  c_toggle: cover property (@(posedge clk_i)
    func == CCM_F_TOGGLE && match_i);
  c_irq: cover property (@(posedge clk_i) irq_o && postscale == CCM_DIV16);
  c_retrig: cover property (@(posedge clk_i) timebase_restart_o);

endmodule : ccm_mode_ctrl

//--- logic/ccm_pkg.sv
// package: register map, field layout and mode codes for mode control
package ccm_pkg;

  // ---------------------------------------------------------------
  // register map (word offsets as byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] CCM_ADDR_LOW = 4'h0;
  localparam logic [3:0] CCM_ADDR_HIGH = 4'h4;
  localparam logic [3:0] CCM_ADDR_STAT = 4'h8;
  localparam logic [15:0] CCM_LOW_RESET = 16'h0000;
  localparam logic [15:0] CCM_HIGH_RESET = 16'h0000;
  localparam logic [15:0] CCM_LOW_WMASK = 16'h00ff;
  localparam logic [15:0] CCM_HIGH_WMASK = 16'hcfff;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CCM_SEL_BIT = 4;
  localparam int CCM_T32_BIT = 5;
  localparam int CCM_SRC_BIT = 15;
  localparam int CCM_RTRG_BIT = 14;
  localparam int CCM_TRG_BIT = 7;
  localparam int CCM_ONE_BIT = 6;
  localparam int CCM_ALT_BIT = 5;

  localparam logic [4:0] CCM_SYNC_NONE = 5'h00;
  localparam logic [4:0] CCM_SYNC_FREE = 5'h1f;
  localparam logic [15:0] CCM_CNT_MAX = 16'hffff;

  // ---------------------------------------------------------------
  // mode codes
  // ---------------------------------------------------------------
  localparam logic [3:0] CCM_CAP_BOTH0 = 4'h0;
  localparam logic [3:0] CCM_CAP_RISE = 4'h1;
  localparam logic [3:0] CCM_CAP_FALL = 4'h2;
  localparam logic [3:0] CCM_CAP_BOTH = 4'h3;
  localparam logic [3:0] CCM_CAP_RISE4 = 4'h4;
  localparam logic [3:0] CCM_CAP_RISE16 = 4'h5;
  localparam logic [3:0] CCM_CMP_TIMER = 4'h0;
  localparam logic [3:0] CCM_CMP_HIGH = 4'h1;
  localparam logic [3:0] CCM_CMP_LOW = 4'h2;
  localparam logic [3:0] CCM_CMP_TOGGLE = 4'h3;
  localparam logic [3:0] CCM_CMP_DUAL = 4'h4;
  localparam logic [3:0] CCM_CMP_DUALB = 4'h5;
  localparam logic [3:0] CCM_CMP_CENTER = 4'h6;
  localparam logic [3:0] CCM_CMP_VFREQ = 4'h7;
  localparam logic [3:0] CCM_CMP_EXT = 4'hf;
  localparam logic [3:0] CCM_DIV4 = 4'h3;
  localparam logic [3:0] CCM_DIV16 = 4'hf;

  typedef enum logic [3:0] {
    CCM_F_NONE, CCM_F_CAPTURE, CCM_F_TIMER, CCM_F_SET_HIGH,
    CCM_F_SET_LOW, CCM_F_TOGGLE, CCM_F_DUAL, CCM_F_DUAL_BUF,
    CCM_F_CENTER, CCM_F_VFREQ, CCM_F_EXTERNAL
  } ccm_func_t;

  typedef struct packed {
    logic [15:0] low;
    logic [15:0] high;
    logic [3:0] edge_cnt;
    logic [3:0] post_cnt;
    logic cap_prev;
    logic cmp_out;
    logic capture;
    logic irq;
    logic ack;
    logic [15:0] rdata;
  } ccm_state_t;

endpackage : ccm_pkg

//--- sim/ccm_mode_ctrl_bench.sv
// self-checking bench for the capture/compare mode control block
`timescale 1ns/10ps
module ccm_mode_ctrl_bench import ccm_pkg::*;;
  // ---------------------------------------------------------------
  // stimulus and design
  // ---------------------------------------------------------------
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic we_i = 1'b0, cap_in_i = 1'b0, match_i = 1'b0;
  logic period_evt_i = 1'b0, trig_evt_i = 1'b0, trigger_i = 1'b0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic ack_o, cmp_out_o, capture_o, irq_o, timebase_restart_o;
  logic pulse_gen_en_o, buffered_o, time32_o, period_rollover_o;
  logic one_shot_o, alt_sync_o;
  logic [4:0] sync_select_o;
  ccm_func_t func_o;
  int err_count = 0, cmp_count = 0, cycles = 0, cap_n = 0, irq_n = 0;
  logic [15:0] q;

  ccm_mode_ctrl u_ccm_mode_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .cap_in_i(cap_in_i), .match_i(match_i), .period_evt_i(period_evt_i),
    .trig_evt_i(trig_evt_i), .trigger_i(trigger_i),
    .cmp_out_o(cmp_out_o), .capture_o(capture_o), .irq_o(irq_o),
    .timebase_restart_o(timebase_restart_o),
    .pulse_gen_en_o(pulse_gen_en_o), .buffered_o(buffered_o),
    .time32_o(time32_o), .period_rollover_o(period_rollover_o),
    .one_shot_o(one_shot_o), .alt_sync_o(alt_sync_o),
    .sync_select_o(sync_select_o), .func_o(func_o));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // pulse counters and hang guard
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (capture_o === 1'b1) cap_n++;
    if (irq_o === 1'b1) irq_n++;
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // ---------------------------------------------------------------
  // bus cycle: hold request until ack is sampled, then release
  // ---------------------------------------------------------------
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [15:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a;
    dat_i <= {16'h0000, d}; sel_i <= 4'h3;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o[15:0];
    cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
  endtask : wb

  // which: 0 match, 1 period event, 2 trigger event, 3 capture input
  task automatic pulse(input int which, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge clk_i);
      case (which)
        0: match_i <= ~match_i;
        1: period_evt_i <= ~period_evt_i;
        2: trig_evt_i <= ~trig_evt_i;
        default: begin
          cap_in_i <= ~cap_in_i;
          @(posedge clk_i);
        end
      endcase
    end
    repeat (3) @(posedge clk_i);
  endtask : pulse

  function automatic ccm_func_t f_exp(input logic s, input logic [3:0] m);
    if (s) return (m <= 4'h5) ? CCM_F_CAPTURE : CCM_F_NONE;
    case (m)
      4'h0: return CCM_F_TIMER;
      4'h1: return CCM_F_SET_HIGH;
      4'h2: return CCM_F_SET_LOW;
      4'h3: return CCM_F_TOGGLE;
      4'h4: return CCM_F_DUAL;
      4'h5: return CCM_F_DUAL_BUF;
      4'h6: return CCM_F_CENTER;
      4'h7: return CCM_F_VFREQ;
      4'hf: return CCM_F_EXTERNAL;
      default: return CCM_F_NONE;
    endcase
  endfunction : f_exp

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  logic [3:0] cm [8] = '{4'h1, 4'h2, 4'h3, 4'h0, 4'h4, 4'h5, 4'h8, 4'h6};
  int ce [8] = '{16, 16, 32, 32, 4, 1, 0, 0};
  int c0, i0;
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, CCM_ADDR_LOW, 0); chk("low rst", CCM_LOW_RESET, q);
    wb(0, CCM_ADDR_HIGH, 0); chk("high rst", CCM_HIGH_RESET, q);
    wb(0, CCM_ADDR_STAT, 0); chk("stat rst", 32'(CCM_F_TIMER), q);
    wb(1, 4'hc, 16'hffff); wb(0, 4'hc, 0); chk("unmapped", 0, q);
    wb(1, CCM_ADDR_HIGH, 16'hffff); wb(0, CCM_ADDR_HIGH, 0);
    chk("high mask", CCM_HIGH_WMASK, q);
    chk("ctl bits", 7'h7f, {one_shot_o, alt_sync_o, sync_select_o});
    chk("free run", 0, period_rollover_o);
    wb(1, CCM_ADDR_HIGH, 16'h0055);
    chk("ctl mix", 7'h55, {one_shot_o, alt_sync_o, sync_select_o});
    wb(1, CCM_ADDR_LOW, 16'hffff); wb(0, CCM_ADDR_LOW, 0);
    chk("low mask", CCM_LOW_WMASK, q);
    // every select and mode code decodes as documented
    for (int k = 0; k < 32; k++) begin
      wb(1, CCM_ADDR_LOW, 16'(k[4:0]));
      chk("func", f_exp(k[4], k[3:0]), func_o);
      if (k == 15) chk("pulse gen", 0, pulse_gen_en_o);
      if (k inside {4, 5, 6}) chk("buffered", k != 4, buffered_o);
    end
    chk("time32 off", 0, time32_o);
    wb(1, CCM_ADDR_LOW, 16'h0020); chk("time32", 1, time32_o);
    // retrigger needs both enables
    wb(1, CCM_ADDR_HIGH, 16'h4080);
    @(posedge clk_i) trigger_i <= 1'b1;
    @(negedge clk_i) chk("restart", 1, timebase_restart_o);
    wb(1, CCM_ADDR_HIGH, 16'h0080);
    @(negedge clk_i) chk("no restart", 0, timebase_restart_o);
    wb(1, CCM_ADDR_HIGH, 16'h4000);
    @(negedge clk_i) chk("no trig en", 0, timebase_restart_o);
    @(posedge clk_i) trigger_i <= 1'b0;
    // single edge compare outputs
    wb(1, CCM_ADDR_HIGH, 16'h0000);
    chk("rollover", 1, period_rollover_o);
    chk("ctl clear", 7'h00, {one_shot_o, alt_sync_o, sync_select_o});
    wb(1, CCM_ADDR_LOW, 16'(CCM_CMP_TOGGLE));
    pulse(0, 1); chk("toggle a", 1, cmp_out_o);
    pulse(0, 1); chk("toggle b", 0, cmp_out_o);
    wb(1, CCM_ADDR_LOW, 16'(CCM_CMP_HIGH));
    pulse(0, 1); chk("set high", 1, cmp_out_o);
    wb(1, CCM_ADDR_LOW, 16'(CCM_CMP_LOW));
    pulse(0, 1); chk("set low", 0, cmp_out_o);
    wb(1, CCM_ADDR_LOW, 16'(CCM_CMP_HIGH)); pulse(0, 1);
    wb(1, CCM_ADDR_LOW, 16'h0009);
    pulse(0, 1); chk("reserved out", 0, cmp_out_o);
    wb(1, CCM_ADDR_LOW, 16'(CCM_CMP_TIMER));
    pulse(0, 1); chk("timer out", 0, cmp_out_o);
    // postscaler source and count
    wb(1, CCM_ADDR_HIGH, 16'h0300); i0 = irq_n;
    pulse(1, 8); pulse(2, 4); chk("irq period", 2, irq_n - i0);
    wb(1, CCM_ADDR_HIGH, 16'h8300); i0 = irq_n;
    pulse(2, 8); pulse(1, 4); chk("irq trig", 2, irq_n - i0);
    wb(1, CCM_ADDR_HIGH, 16'h8000); i0 = irq_n;
    pulse(2, 3); chk("irq each trig", 3, irq_n - i0);
    wb(1, CCM_ADDR_HIGH, 16'h0000); i0 = irq_n;
    pulse(1, 3); chk("irq each period", 3, irq_n - i0);
    wb(1, CCM_ADDR_LOW, 16'h0008); i0 = irq_n;
    pulse(1, 4); chk("irq reserved", 0, irq_n - i0);
    // capture edge modes, one interrupt per capture
    wb(1, CCM_ADDR_HIGH, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      wb(1, CCM_ADDR_LOW, 16'h0000);
      wb(1, CCM_ADDR_LOW, {12'h001, cm[k]});
      c0 = cap_n; i0 = irq_n;
      pulse(3, 16);
      chk("captures", ce[k], cap_n - c0);
      chk("cap irq", ce[k], irq_n - i0);
    end
    tally_and_finish();
  end
endmodule : ccm_mode_ctrl_bench
